// ==== verilog/output_config_cfg.svh ====
// output_config_cfg.svh: bit positions, counts and defaults for the output configuration word
// assumes: included by bare name from the design modules
`ifndef OUTPUT_CONFIG_CFG_SVH
`define OUTPUT_CONFIG_CFG_SVH

// ----------------------------------------------------------------------------
// word layout
// ----------------------------------------------------------------------------
`define CFG_WORD_W          32
`define CFG_SEL_CODE        2'h1
`define CFG_SIGSEL_LSB      2
`define CFG_MODE_LSB        7
`define CFG_REFSTAT_BIT     27
`define CFG_SHARED_BIT      28
`define CFG_LOCK_BIT        29
`define CFG_QDIV4_BIT       30
`define CFG_QDIV8_BIT       31
`define CFG_PAIRS           5
`define CFG_OUTPUTS         10

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CFG_WORD_RESET      32'h0000007d

`endif

// ==== verilog/output_config_pkg.sv ====
// output_config_pkg.sv: types shared by the output configuration block
// assumes: nothing beyond the configuration header
package output_config_pkg;

    typedef enum logic [1:0] {
        quad_off_t_none = 2'b00,
        quad_div_four   = 2'b01,
        quad_div_eight  = 2'b10
    } quad_mode_t;

    typedef logic [1:0] out_mode_t;

endpackage

// ==== verilog/pin_sync3.sv ====
// pin_sync3.sv: three-stage pin synchroniser, a change counts once stages two and three agree
// assumes: input is asynchronous to mclk
`timescale 1ns/1ps
module pin_sync3 (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // pin and clean level
    input  wire logic pin_in,
    output logic      level_out
);
    logic [2:0] stage_r;
    logic [2:0] stage_nxt;
    logic       level_r;
    logic       level_nxt;

    always_comb begin
        stage_nxt = {stage_r[1:0], pin_in};
        level_nxt = (stage_r[1] == stage_r[2]) ? stage_r[2] : level_r;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stage_r <= 3'h0;
            level_r <= 1'b0;
        end else begin
            stage_r <= stage_nxt;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;
endmodule

// ==== verilog/quad_decode.sv ====
// quad_decode.sv: decodes the two quadrature enables into one shift mode
// assumes: fed from the stored word on the same clock
`timescale 1ns/1ps
module quad_decode
    import output_config_pkg::*;
(
    // enable bits
    input  wire logic div_four_en,
    input  wire logic div_eight_en,
    // decoded mode
    output quad_mode_t mode
);
    always_comb begin
        unique case ({div_eight_en, div_four_en})
            2'b01:   mode = quad_div_four;
            2'b10:   mode = quad_div_eight;
            default: mode = quad_off_t_none;
        endcase
    end
endmodule

// ==== verilog/output_config_word.sv ====
// output_config_word.sv: second configuration word of the clock synchroniser
// assumes: a serial shifter hands over whole 32-bit words with a one-cycle strobe,
// reference status inputs arrive from outside the mclk domain
//
// Functional notes
// - bits 2..6 pick pair signaling, default one
// - bits 7..26 are ten two-bit output modes
// - bit27 zero: refstat pin shows reference validity
// - bit27 one: refstat high primary, low secondary
// - bit28 picks oscillator status or resistor input
// - bit29 picks digital or analog lock style
// - bit30 enables quadrature shift in divide-by-four
// - bit31 enables quadrature shift in divide-by-eight
// - quadrature active removes divide-by-16 output ratio
// - quadrature shift applies to output pairs
// - both quadrature bits set means no shift
// - whole-word writes only, no readback or handshake
// - defaults restored at power-up and power-down
`timescale 1ns/1ps
`include "output_config_cfg.svh"
module output_config_word
    import output_config_pkg::*;
(
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    // word from the serial shifter
    input  wire logic [`CFG_WORD_W-1:0]        word_in,
    input  wire logic                          word_strobe,
    // power-down control, active low
    input  wire logic                          power_down_b,
    // reference status inputs
    input  wire logic                          ref_valid,
    input  wire logic                          primary_selected,
    // configured pair and output settings
    output logic [`CFG_PAIRS-1:0]              pair_signaling_select,
    output logic [2*`CFG_OUTPUTS-1:0]          output_mode,
    // status pin controls
    output logic                               refstat_pin,
    output logic                               shared_pin_function,
    output logic                               lock_style_select,
    // quadrature controls
    output logic                               quadrature_div_four_active,
    output logic                               quadrature_div_eight_active,
    output logic [`CFG_PAIRS-1:0]              pair_quadrature_enable,
    output logic                               div_sixteen_allowed
);
    // ------------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_int_b;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_int_b = rst_sync_r[1];

    // ------------------------------------------------------------------------
    // pin inputs
    // ------------------------------------------------------------------------
    logic pd_s;
    logic pd_b_s;
    logic ref_valid_s;
    logic primary_s;

    // synchronise the active-high form so reset leaves power-down inactive
    pin_sync3 u_sync_pd (
        .mclk      (mclk),
        .rst_b     (rst_int_b),
        .pin_in    (!power_down_b),
        .level_out (pd_s)
    );

    assign pd_b_s = !pd_s;

    pin_sync3 u_sync_valid (
        .mclk      (mclk),
        .rst_b     (rst_int_b),
        .pin_in    (ref_valid),
        .level_out (ref_valid_s)
    );

    pin_sync3 u_sync_prim (
        .mclk      (mclk),
        .rst_b     (rst_int_b),
        .pin_in    (primary_selected),
        .level_out (primary_s)
    );

    // ------------------------------------------------------------------------
    // stored word
    // ------------------------------------------------------------------------
    logic [`CFG_WORD_W-1:0] word_r;
    logic [`CFG_WORD_W-1:0] word_nxt;

    always_comb begin
        word_nxt = word_r;
        if (!pd_b_s) begin
            word_nxt = `CFG_WORD_RESET;
        end else if (word_strobe && (word_in[1:0] == `CFG_SEL_CODE)) begin
            word_nxt = word_in;
        end
    end

    always_ff @(posedge mclk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            word_r <= `CFG_WORD_RESET;
        end else begin
            word_r <= word_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // quadrature decode
    // ------------------------------------------------------------------------
    quad_mode_t quad_mode;

    quad_decode u_quad (
        .div_four_en  (word_r[`CFG_QDIV4_BIT]),
        .div_eight_en (word_r[`CFG_QDIV8_BIT]),
        .mode         (quad_mode)
    );

    // ------------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------------
    logic [`CFG_PAIRS-1:0]     sig_r;
    logic [`CFG_PAIRS-1:0]     sig_nxt;
    logic [2*`CFG_OUTPUTS-1:0] mode_r;
    logic [2*`CFG_OUTPUTS-1:0] mode_nxt;
    logic                      refstat_r;
    logic                      refstat_nxt;
    logic                      shared_r;
    logic                      shared_nxt;
    logic                      lock_r;
    logic                      lock_nxt;
    logic                      q4_r;
    logic                      q4_nxt;
    logic                      q8_r;
    logic                      q8_nxt;
    logic [`CFG_PAIRS-1:0]     pairq_r;
    logic [`CFG_PAIRS-1:0]     pairq_nxt;
    logic                      d16_r;
    logic                      d16_nxt;
    logic                      quad_any;

    genvar g;
    generate
        for (g = 0; g < `CFG_PAIRS; g = g + 1) begin : g_pair
            // both outputs of a pair shift together
            assign pairq_nxt[g] = quad_any;
            assign sig_nxt[g]   = word_r[`CFG_SIGSEL_LSB + g];
        end
    endgenerate

    always_comb begin
        quad_any    = (quad_mode != quad_off_t_none);
        mode_nxt    = word_r[`CFG_MODE_LSB +: 2*`CFG_OUTPUTS];
        if (word_r[`CFG_REFSTAT_BIT]) begin
            refstat_nxt = primary_s;
        end else begin
            refstat_nxt = ref_valid_s;
        end
        shared_nxt  = word_r[`CFG_SHARED_BIT];
        lock_nxt    = word_r[`CFG_LOCK_BIT];
        q4_nxt      = (quad_mode == quad_div_four);
        q8_nxt      = (quad_mode == quad_div_eight);
        // any set enable bit removes divide-by-16, even when both cancel
        d16_nxt     = !(word_r[`CFG_QDIV4_BIT] || word_r[`CFG_QDIV8_BIT]);
    end

    always_ff @(posedge mclk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            sig_r     <= 5'h1f;
            mode_r    <= 20'h00000;
            refstat_r <= 1'b0;
            shared_r  <= 1'b0;
            lock_r    <= 1'b0;
            q4_r      <= 1'b0;
            q8_r      <= 1'b0;
            pairq_r   <= 5'h00;
            d16_r     <= 1'b1;
        end else begin
            sig_r     <= sig_nxt;
            mode_r    <= mode_nxt;
            refstat_r <= refstat_nxt;
            shared_r  <= shared_nxt;
            lock_r    <= lock_nxt;
            q4_r      <= q4_nxt;
            q8_r      <= q8_nxt;
            pairq_r   <= pairq_nxt;
            d16_r     <= d16_nxt;
        end
    end

    assign pair_signaling_select       = sig_r;
    assign output_mode                 = mode_r;
    assign refstat_pin                 = refstat_r;
    assign shared_pin_function         = shared_r;
    assign lock_style_select           = lock_r;
    assign quadrature_div_four_active  = q4_r;
    assign quadrature_div_eight_active = q8_r;
    assign pair_quadrature_enable      = pairq_r;
    assign div_sixteen_allowed         = d16_r;
endmodule

// ==== bench/cfg_host_model.sv ====
// cfg_host_model.sv: host that hands whole configuration words to the block
// assumes: bench raises send_req just after a rising edge of mclk
`timescale 1ns/1ps
module cfg_host_model (
    // clock
    input  wire logic        mclk,
    // bench request
    input  wire logic        send_req,
    input  wire logic [31:0] send_word,
    // shifter side
    output logic [31:0]      word_in = 32'h0,
    output logic             word_strobe = 1'b0
);
// ----------------------------------------
// word hand-over, no answer is awaited
// ----------------------------------------
// feedback divide-by-16 lives in another word, assumed set by the host
// scenarios set one quadrature bit per word, except the deliberate both-set case
always @(posedge mclk) begin
    word_strobe <= send_req;
    word_in     <= send_req ? send_word : ~word_in;
end
endmodule

// ==== bench/output_config_props.sv ====
// output_config_props.sv: assertions on the output configuration word ports
// assumes: bound to output_config_word, power-down not toggled around strobes
`timescale 1ns/1ps
module output_config_props (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // inputs
    input wire logic [31:0] word_in,
    input wire logic        word_strobe,
    input wire logic        power_down_b,
    // outputs
    input wire logic [4:0]  pair_signaling_select,
    input wire logic [19:0] output_mode,
    input wire logic        shared_pin_function,
    input wire logic        lock_style_select,
    input wire logic        quadrature_div_four_active,
    input wire logic        quadrature_div_eight_active,
    input wire logic [4:0]  pair_quadrature_enable,
    input wire logic        div_sixteen_allowed
);
default clocking @(posedge mclk); endclocking
default disable iff (!rst_b);
wire logic q4 = quadrature_div_four_active;
wire logic q8 = quadrature_div_eight_active;
sequence taken;
    word_strobe && word_in[1:0] == 2'h1 && power_down_b && $past(power_down_b, 4);
endsequence
chk_pair_select: assert property (taken |-> ##2 pair_signaling_select == $past(word_in[6:2], 2))
    else $error("pair select mismatch");
chk_mode_fields: assert property (taken |-> ##2 output_mode == $past(word_in[26:7], 2))
    else $error("mode fields mismatch");
chk_shared_pin: assert property (taken |-> ##2 shared_pin_function == $past(word_in[28], 2))
    else $error("shared pin mismatch");
chk_lock_style: assert property (taken |-> ##2 lock_style_select == $past(word_in[29], 2))
    else $error("lock style mismatch");
chk_quad_four: assert property (taken |-> ##2 q4 == ($past(word_in[31:30], 2) == 2'h1))
    else $error("div-4 shift mismatch");
chk_quad_eight: assert property (taken |-> ##2 q8 == ($past(word_in[31:30], 2) == 2'h2))
    else $error("div-8 shift mismatch");
chk_div16_gone: assert property (taken |-> ##2 div_sixteen_allowed == !$past(|word_in[31:30], 2))
    else $error("div-16 availability mismatch");
chk_pair_shift: assert property (pair_quadrature_enable == {5{q4 || q8}})
    else $error("pair shift mismatch");
chk_both_off: assert property (!(q4 && q8))
    else $error("both shifts active");
chk_word_refused: assert property (word_strobe && word_in[1:0] != 2'h1 && power_down_b
    |-> ##2 $stable(output_mode)) else $error("refused word stored");
chk_pd_default: assert property (!power_down_b [*7] |-> pair_signaling_select == 5'h1f
    && output_mode == 20'h0 && div_sixteen_allowed) else $error("no default");
cover property (taken ##1 taken);
cover property (taken ##2 q4);
cover property (taken ##2 q8);
endmodule
bind output_config_word output_config_props output_config_props_i (.mclk, .rst_b, .word_in,
    .word_strobe, .power_down_b, .pair_signaling_select, .output_mode, .shared_pin_function,
    .lock_style_select, .quadrature_div_four_active, .quadrature_div_eight_active,
    .pair_quadrature_enable, .div_sixteen_allowed);

// ==== bench/tb_top.sv ====
// tb_top.sv: self-checking bench for the output configuration word
// assumes: host model drives the word port, bench drives pins at rising edges
`timescale 1ns/1ps
module tb_top;
logic mclk = 1'b0, rst_b = 1'b0, power_down_b = 1'b1, send_req = 1'b0;
logic ref_valid = 1'b0, primary_selected = 1'b0;
logic [31:0] send_word = 32'h0, word_in;
logic word_strobe, refstat_pin, shared_pin_function, lock_style_select, div_sixteen_allowed;
logic quadrature_div_four_active, quadrature_div_eight_active;
logic [4:0] pair_signaling_select, pair_quadrature_enable;
logic [19:0] output_mode;
int bad_count = 0, comparisons = 0;
cfg_host_model cfg_host_model_i (.mclk, .send_req, .send_word, .word_in, .word_strobe);
output_config_word output_config_word_i (.mclk, .rst_b, .word_in, .word_strobe,
    .power_down_b, .ref_valid, .primary_selected, .pair_signaling_select, .output_mode,
    .refstat_pin, .shared_pin_function, .lock_style_select, .quadrature_div_four_active,
    .quadrature_div_eight_active, .pair_quadrature_enable, .div_sixteen_allowed);
initial forever #50 mclk = ~mclk;
// ----------------------------------------
// helpers
// ----------------------------------------
task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
        bad_count++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task cyc(input int n);
    repeat (n) @(posedge mclk);
endtask
task send(input logic [31:0] w);
    @(posedge mclk);
    send_req <= 1'b1;
    send_word <= w;
    @(posedge mclk);
    send_req <= 1'b0;
    cyc(4);
endtask
task check_word(input logic [31:0] w);
    logic q;
    q = w[30] ^ w[31];
    @(negedge mclk);
    chk(pair_signaling_select, w[6:2]);
    chk(output_mode, w[26:7]);
    chk({lock_style_select, shared_pin_function}, w[29:28]);
    chk({quadrature_div_eight_active, quadrature_div_four_active}, {2{q}} & w[31:30]);
    chk(pair_quadrature_enable, {5{q}});
    chk(div_sixteen_allowed, !(w[30] | w[31]));
endtask
task give_verdict;
    $display("counts: bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_quad;
    @(posedge mclk);
    send_req <= 1'b1;
    send_word <= 32'h41555549;
    @(posedge mclk);
    send_word <= 32'h8aaaaab5;
    @(posedge mclk);
    send_req <= 1'b0;
    cyc(4);
    check_word(32'h8aaaaab5);
    send(32'hf5a5a5a5);
    check_word(32'hf5a5a5a5);
    send(32'h41555549);
    check_word(32'h41555549);
endtask
task t_refused;
    for (int c = 0; c < 4; c++) begin
        if (c != 1) begin
            send({30'h2eaaaaa9, c[1:0]});
            check_word(32'h41555549);
        end
    end
endtask
task t_refstat;
    for (int s = 0; s < 2; s++) begin
        send(s ? 32'h49555549 : 32'h41555549);
        for (int v = 0; v < 2; v++) begin
            @(posedge mclk);
            ref_valid <= v[0];
            primary_selected <= !v[0];
            cyc(6);
            @(negedge mclk);
            chk(refstat_pin, s[0] ^ v[0]);
        end
    end
endtask
task t_power;
    @(posedge mclk);
    power_down_b <= 1'b0;
    cyc(8);
    check_word(32'h0000007d);
    send(32'h8aaaaab5);
    check_word(32'h0000007d);
    @(posedge mclk);
    power_down_b <= 1'b1;
    cyc(6);
    check_word(32'h0000007d);
    send(32'h8aaaaab5);
    check_word(32'h8aaaaab5);
endtask
initial begin
    cyc(8);
    rst_b <= 1'b1;
    cyc(4);
    check_word(32'h0000007d);
    t_quad();
    t_refused();
    t_refstat();
    t_power();
    give_verdict();
end
endmodule
